// ---- verilog/sprx_pkg.sv ----
// Constants shared by the serial paged register port
package sprx_pkg;

   // Serial word and command field layout
   localparam int WORD_BITS = 16;
   localparam int CMD_DIR_BIT = 15;
   localparam int PAGE_SELECT_MSB = 14;
   localparam int PAGE_SELECT_LSB = 11;
   localparam int REGISTER_INDEX_MSB = 10;
   localparam int REGISTER_INDEX_LSB = 5;
   localparam int BIT_COUNT_LAST = 15;

   // Page codes; every other code is reserved
   localparam logic [3:0] PAGE_DATA = 4'h0;
   localparam logic [3:0] PAGE_TOUCH = 4'h1;
   localparam logic [3:0] PAGE_AUDIO = 4'h2;

   // Page geometry and fill values
   localparam int PAGE0_DEPTH = 8;
   localparam int PAGE_DEPTH = 32;
   localparam logic [5:0] PAGE_LAST_ADDR = 6'h1f;
   localparam logic [15:0] PAST_END_VALUE = 16'hffff;
   localparam logic [15:0] RESET_VALUE = 16'h0000;

   // Page 0 result offsets
   localparam logic [5:0] X_POSITION_RESULT = 6'h00;
   localparam logic [5:0] Y_POSITION_RESULT = 6'h01;
   localparam logic [5:0] PRESSURE_ONE_RESULT = 6'h02;
   localparam logic [5:0] PRESSURE_TWO_RESULT = 6'h03;
   localparam logic [5:0] BATTERY_ONE_RESULT = 6'h05;
   localparam logic [5:0] BATTERY_TWO_RESULT = 6'h06;
   localparam logic [5:0] AUXILIARY_INPUT_RESULT = 6'h07;

   // Page 1 offsets
   localparam logic [5:0] TOUCH_CONVERTER_CONTROL = 6'h00;
   localparam logic [5:0] TOUCH_STATUS = 6'h01;
   localparam logic [5:0] REFERENCE_CONTROL = 6'h03;
   localparam logic [5:0] SOFT_RESET_CONTROL = 6'h04;
   localparam logic [5:0] TOUCH_CONFIGURATION = 6'h05;

   // Page 2 offsets; coefficients run from the first to the last
   localparam logic [5:0] AUDIO_CONTROL_ONE = 6'h00;
   localparam logic [5:0] DAC_VOLUME = 6'h02;
   localparam logic [5:0] AUDIO_CONTROL_TWO = 6'h04;
   localparam logic [5:0] DAC_POWER_CONTROL = 6'h05;
   localparam logic [5:0] AUDIO_CONTROL_THREE = 6'h06;
   localparam logic [5:0] FILTER_COEFFICIENT_FIRST = 6'h07;
   localparam logic [5:0] FILTER_COEFFICIENT_LAST = 6'h1d;

   // One bit per implemented address; clear bits are reserved
   localparam logic [7:0] PAGE0_IMPL = 8'hef;
   localparam logic [31:0] PAGE1_IMPL = 32'h0000003b;
   localparam logic [31:0] PAGE2_IMPL = 32'h3ffffff5;

   // Access sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CMD = 2'b01,
      ST_DATA = 2'b10
   } sprx_state_t;

endpackage

// ---- verilog/sprx_ser_if.sv ----
// Word level link between the serial shifter and the register core
interface sprx_ser_if;
   logic word_valid;
   logic [15:0] rx_word;
   logic [15:0] tx_word;
   logic frame_start;

   modport shifter (
      output word_valid,
      output rx_word,
      output frame_start,
      input tx_word
   );

   modport core (
      input word_valid,
      input rx_word,
      input frame_start,
      output tx_word
   );
endinterface

// ---- verilog/sprx_shift.sv ----
// Serial pin synchroniser and 16-bit full duplex shifter
module sprx_shift (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic ss_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   sprx_ser_if.shifter ser
);

   logic sclk_s1, sclk_s2, sclk_s3;
   logic ss_s1, ss_s2, ss_s3;
   logic mosi_s1, mosi_s2;
   logic [3:0] bit_cnt;
   logic [15:0] rx_sh;
   logic [15:0] tx_sh;

   // Edges seen after the second stage only; first stages feed nothing else
   wire sclk_rise = sclk_s2 & ~sclk_s3;
   wire sclk_fall = ~sclk_s2 & sclk_s3;
   wire selected = ~ss_s2;
   wire ss_fall = ss_s3 & ~ss_s2;
   wire [15:0] rx_next = {rx_sh[14:0], mosi_s2};
   wire last_bit = (bit_cnt == 4'(sprx_pkg::BIT_COUNT_LAST));

   // Pin synchronisers; select resets low so a select already low at
   // release shows no fall: only a fresh select fall arms a command
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
         {ss_s1, ss_s2, ss_s3} <= 3'h0;
         {mosi_s1, mosi_s2} <= 2'h0;
      end else begin
         {sclk_s1, sclk_s2, sclk_s3} <= {sclk, sclk_s1, sclk_s2};
         {ss_s1, ss_s2, ss_s3} <= {ss_n, ss_s1, ss_s2};
         {mosi_s1, mosi_s2} <= {mosi, mosi_s1};
      end
   end

   // Shift engine: out on the rising edge, in on the falling edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt <= 4'h0;
         rx_sh <= 16'h0000;
         tx_sh <= 16'h0000;
         miso <= 1'b0;
         miso_oe <= 1'b0;
         ser.word_valid <= 1'b0;
         ser.rx_word <= 16'h0000;
         ser.frame_start <= 1'b0;
      end else begin
         ser.word_valid <= 1'b0;
         ser.frame_start <= ss_fall;
         if (!selected) begin
            bit_cnt <= 4'h0;
            miso_oe <= 1'b0;
         end else begin
            if (sclk_rise) begin
               miso_oe <= 1'b1;
               if (bit_cnt == 4'h0) begin
                  miso <= ser.tx_word[15];
                  tx_sh <= {ser.tx_word[14:0], 1'b0};
               end else begin
                  miso <= tx_sh[15];
                  tx_sh <= {tx_sh[14:0], 1'b0};
               end
            end
            if (sclk_fall) begin
               rx_sh <= rx_next;
               bit_cnt <= bit_cnt + 4'h1;
               if (last_bit) begin
                  ser.word_valid <= 1'b1;
                  ser.rx_word <= rx_next;
               end
            end
         end
      end
   end

   a_miso_release: assert property (
      @(posedge clk) disable iff (!rst_n)
      !selected |=> !miso_oe && bit_cnt == 4'h0)
      else $error("miso still driven or count kept with select high");

   a_drive_first_edge: assert property (
      @(posedge clk) disable iff (!rst_n)
      selected && sclk_rise |=> miso_oe)
      else $error("miso not driven after first clock edge");

   a_sample_on_fall: assert property (
      @(posedge clk) disable iff (!rst_n)
      ser.word_valid |-> $past(sclk_fall) && $past(last_bit))
      else $error("word completed away from falling edge");

endmodule

// ---- verilog/sprx_top.sv ----
// Serial paged register port with three pages of 16-bit registers
module sprx_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic ss_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   input wire logic result_valid,
   input wire logic [2:0] result_index,
   input wire logic [15:0] result_value,
   output logic [15:0] touch_converter_control,
   output logic [15:0] touch_status,
   output logic [15:0] reference_control,
   output logic [15:0] soft_reset_control,
   output logic [15:0] touch_configuration,
   output logic [15:0] audio_control_one,
   output logic [15:0] dac_volume,
   output logic [15:0] audio_control_two,
   output logic [15:0] dac_power_control,
   output logic [15:0] audio_control_three
);

   sprx_ser_if ser ();

   sprx_pkg::sprx_state_t state;
   sprx_pkg::sprx_state_t next_state;
   logic rd_mode;
   logic [3:0] page;
   logic [5:0] ptr;
   logic over;
   logic [15:0] tx_word;
   logic [15:0] page0 [0:sprx_pkg::PAGE0_DEPTH-1];
   logic [15:0] page1 [0:sprx_pkg::PAGE_DEPTH-1];
   logic [15:0] page2 [0:sprx_pkg::PAGE_DEPTH-1];

   // clock and frames come from the master
   sprx_shift u_shift (
      .clk(clk),
      .rst_n(rst_n),
      .sclk(sclk),
      .ss_n(ss_n),
      .mosi(mosi),
      .miso(miso),
      .miso_oe(miso_oe),
      .ser(ser)
   );

   // Command field decode
   // direction bit
   wire cmd_read = ser.rx_word[sprx_pkg::CMD_DIR_BIT];
   wire [3:0] cmd_page =
      ser.rx_word[sprx_pkg::PAGE_SELECT_MSB:sprx_pkg::PAGE_SELECT_LSB];
   wire [5:0] cmd_addr =
      ser.rx_word[sprx_pkg::REGISTER_INDEX_MSB:sprx_pkg::REGISTER_INDEX_LSB];

   // Access qualifiers; bits 4..0 of the command are not looked at
   wire cmd_word = ser.word_valid && (state == sprx_pkg::ST_CMD);
   wire data_word = ser.word_valid && (state == sprx_pkg::ST_DATA);
   wire beyond = over || (ptr > sprx_pkg::PAGE_LAST_ADDR);
   wire at_last = (ptr == sprx_pkg::PAGE_LAST_ADDR);
   wire wr_go = data_word && !rd_mode && !beyond;
   wire [4:0] slot = ptr[4:0];
   wire wr_touch = wr_go && (page == sprx_pkg::PAGE_TOUCH);
   wire wr_audio = wr_go && (page == sprx_pkg::PAGE_AUDIO);

   // Sequencer: a select fall arms a command, the rest of the frame is data
   always_comb begin
      next_state = state;
      unique case (state)
         sprx_pkg::ST_IDLE: begin
            next_state = sprx_pkg::ST_IDLE;
         end
         sprx_pkg::ST_CMD: begin
            if (ser.word_valid) begin
               next_state = sprx_pkg::ST_DATA;
            end
         end
         sprx_pkg::ST_DATA: begin
            next_state = sprx_pkg::ST_DATA;
         end
         default: begin
            next_state = sprx_pkg::ST_IDLE;
         end
      endcase
      // only a select fall opens a command
      if (ser.frame_start) begin
         next_state = sprx_pkg::ST_CMD;
      end
   end

   // State register; a select already low at reset arms nothing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= sprx_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Command capture and pointer walk
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_mode <= 1'b0;
         page <= 4'h0;
         ptr <= 6'h00;
         over <= 1'b0;
      end else if (cmd_word) begin
         rd_mode <= cmd_read;
         page <= cmd_page;
         ptr <= cmd_addr;
         over <= 1'b0;
      end else if (data_word && !beyond) begin
         if (at_last) begin
            over <= 1'b1;
         end else begin
            ptr <= ptr + 6'h01;
         end
      end
   end

   // Page 0 results: loaded by the converter, never by the serial port
   genvar gi;
   generate
      for (gi = 0; gi < sprx_pkg::PAGE0_DEPTH; gi++) begin : g_page0
         if (sprx_pkg::PAGE0_IMPL[gi]) begin : g_impl
            always_ff @(posedge clk or negedge rst_n) begin
               if (!rst_n) begin
                  page0[gi] <= sprx_pkg::RESET_VALUE;
               end else if (result_valid && result_index == 3'(gi)) begin
                  page0[gi] <= result_value;
               end
            end
         end else begin : g_resv
            assign page0[gi] = sprx_pkg::RESET_VALUE;
         end
      end
   endgenerate

   // Control pages 1 and 2; reserved slots hold zero and drop writes
   generate
      for (gi = 0; gi < sprx_pkg::PAGE_DEPTH; gi++) begin : g_ctrl
         if (sprx_pkg::PAGE1_IMPL[gi]) begin : g_p1
            // serial port is the only writer
            always_ff @(posedge clk or negedge rst_n) begin
               if (!rst_n) begin
                  page1[gi] <= sprx_pkg::RESET_VALUE;
               end else if (wr_touch && slot == 5'(gi)) begin
                  page1[gi] <= ser.rx_word;
               end
            end
         end else begin : g_p1_resv
            assign page1[gi] = sprx_pkg::RESET_VALUE;
         end
         if (sprx_pkg::PAGE2_IMPL[gi]) begin : g_p2
            always_ff @(posedge clk or negedge rst_n) begin
               if (!rst_n) begin
                  page2[gi] <= sprx_pkg::RESET_VALUE;
               end else if (wr_audio && slot == 5'(gi)) begin
                  page2[gi] <= ser.rx_word;
               end
            end
         end else begin : g_p2_resv
            assign page2[gi] = sprx_pkg::RESET_VALUE;
         end
      end
   endgenerate

   // Read selection; reserved pages and reads past 1f return all ones; page 0 reads past 7 return zero
   wire [15:0] rd_p0 =
      (ptr < 6'(sprx_pkg::PAGE0_DEPTH)) ? page0[ptr[2:0]] : 16'h0000;
   wire [15:0] rd_page =
      (page == sprx_pkg::PAGE_DATA) ? rd_p0 :
      (page == sprx_pkg::PAGE_TOUCH) ? page1[slot] :
      (page == sprx_pkg::PAGE_AUDIO) ? page2[slot] :
      sprx_pkg::PAST_END_VALUE;
   wire [15:0] rd_data = beyond ? sprx_pkg::PAST_END_VALUE : rd_page;

   // Reply word refreshed every cycle; the shifter takes it at bit 0
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_word <= 16'h0000;
      end else begin
         tx_word <= rd_data;
      end
   end
   assign ser.tx_word = tx_word;

   // Control outputs straight from the register cells
   assign touch_converter_control =
      page1[sprx_pkg::TOUCH_CONVERTER_CONTROL[4:0]];
   assign touch_status = page1[sprx_pkg::TOUCH_STATUS[4:0]];
   assign reference_control = page1[sprx_pkg::REFERENCE_CONTROL[4:0]];
   assign soft_reset_control = page1[sprx_pkg::SOFT_RESET_CONTROL[4:0]];
   assign touch_configuration = page1[sprx_pkg::TOUCH_CONFIGURATION[4:0]];
   assign audio_control_one = page2[sprx_pkg::AUDIO_CONTROL_ONE[4:0]];
   assign dac_volume = page2[sprx_pkg::DAC_VOLUME[4:0]];
   assign audio_control_two = page2[sprx_pkg::AUDIO_CONTROL_TWO[4:0]];
   assign dac_power_control = page2[sprx_pkg::DAC_POWER_CONTROL[4:0]];
   assign audio_control_three = page2[sprx_pkg::AUDIO_CONTROL_THREE[4:0]];

   a_idle_no_command: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == sprx_pkg::ST_IDLE && ser.word_valid && !ser.frame_start
      |=> state == sprx_pkg::ST_IDLE && $stable(ptr) && $stable(page))
      else $error("command taken without a select fall");

   a_page_addr_decode: assert property (
      @(posedge clk) disable iff (!rst_n)
      cmd_word |=> page == $past(ser.rx_word[14:11])
         && ptr == $past(ser.rx_word[10:5]) && !over)
      else $error("page or address not taken from command");

   a_direction_decode: assert property (
      @(posedge clk) disable iff (!rst_n)
      cmd_word |=> rd_mode == $past(ser.rx_word[15])
         && state == sprx_pkg::ST_DATA)
      else $error("direction bit misdecoded");

   a_ptr_advance: assert property (
      @(posedge clk) disable iff (!rst_n)
      data_word && !beyond && !at_last |=> ptr == $past(ptr) + 6'h01)
      else $error("pointer did not advance by one");

   a_past_end_ones: assert property (
      @(posedge clk) disable iff (!rst_n)
      data_word && at_last && !over ##1 !cmd_word |=> tx_word == 16'hffff)
      else $error("read past page end not all ones");

   a_page0_read_only: assert property (
      @(posedge clk) disable iff (!rst_n)
      data_word && page == sprx_pkg::PAGE_DATA && !result_valid
      |=> $stable(page0[0]) && $stable(page0[7]))
      else $error("page 0 changed by a serial access");

   a_write_stores: assert property (
      @(posedge clk) disable iff (!rst_n)
      wr_audio && ptr == sprx_pkg::DAC_VOLUME
      |=> dac_volume == $past(ser.rx_word))
      else $error("write word not stored at pointer");

   a_reserved_page: assert property (
      @(posedge clk) disable iff (!rst_n)
      page > sprx_pkg::PAGE_AUDIO && state == sprx_pkg::ST_DATA
      && !cmd_word ##1 !cmd_word |=> tx_word == 16'hffff)
      else $error("reserved page did not read all ones");

   // Storage and reply checks; each names what it expects to move or to hold
   a_touch_write_stores: assert property (
      @(posedge clk) disable iff (!rst_n)
      wr_touch && ptr == sprx_pkg::REFERENCE_CONTROL
      |=> reference_control == $past(ser.rx_word))
      else $error("touch write word not stored at pointer");

   a_audio_write_stores: assert property (
      @(posedge clk) disable iff (!rst_n)
      wr_audio && ptr == sprx_pkg::AUDIO_CONTROL_THREE
      |=> audio_control_three == $past(ser.rx_word))
      else $error("audio write word not stored at pointer");

   a_beyond_no_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      data_word && !rd_mode && beyond
      |=> $stable(page2[sprx_pkg::FILTER_COEFFICIENT_LAST[4:0]])
         && $stable(reference_control))
      else $error("write past page end was stored");

   a_reserved_no_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      data_word && page > sprx_pkg::PAGE_AUDIO
      |=> $stable(touch_converter_control) && $stable(audio_control_one))
      else $error("reserved page write reached a register");

   a_read_no_store: assert property (
      @(posedge clk) disable iff (!rst_n)
      data_word && rd_mode
      |=> $stable(touch_converter_control) && $stable(dac_volume))
      else $error("read access changed a register");

   a_cmd_not_stored: assert property (
      @(posedge clk) disable iff (!rst_n)
      cmd_word
      |=> $stable(touch_converter_control) && $stable(audio_control_one))
      else $error("command word stored as data");

   a_volume_reply: assert property (
      @(posedge clk) disable iff (!rst_n)
      page == sprx_pkg::PAGE_AUDIO && ptr == sprx_pkg::DAC_VOLUME && !beyond
      |=> tx_word == $past(dac_volume))
      else $error("volume register not offered as reply");

   a_result_reply: assert property (
      @(posedge clk) disable iff (!rst_n)
      page == sprx_pkg::PAGE_DATA
      && ptr == sprx_pkg::X_POSITION_RESULT && !beyond
      |=> tx_word == $past(page0[sprx_pkg::X_POSITION_RESULT[2:0]]))
      else $error("position result not offered as reply");

   a_result_load: assert property (
      @(posedge clk) disable iff (!rst_n)
      result_valid && result_index == sprx_pkg::BATTERY_ONE_RESULT[2:0]
      |=> page0[sprx_pkg::BATTERY_ONE_RESULT[2:0]] == $past(result_value))
      else $error("result word not loaded");

   a_frame_arms_cmd: assert property (
      @(posedge clk) disable iff (!rst_n)
      ser.frame_start |=> state == sprx_pkg::ST_CMD)
      else $error("select fall did not arm a command");

   a_park_at_end: assert property (
      @(posedge clk) disable iff (!rst_n)
      over && !cmd_word
      |=> over && ptr == sprx_pkg::PAGE_LAST_ADDR)
      else $error("pointer left the page end");

endmodule

// ---- verif/sprx_host.sv ----
// Serial bus master model that drives the register port
module sprx_host (
   input wire logic clk,
   output logic sclk,
   output logic ss_n,
   output logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   // Bus idle at time zero
   // clock idles low
   initial begin
      sclk = 1'b0;
      ss_n = 1'b1;
      mosi = 1'b0;
   end

   // Whole system clocks; pins only move on the falling edge
   task automatic ticks(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Select edges; released data shows the inverse so stale bits never help
   task automatic select(input logic on);
      ticks(1);
      ss_n = ~on;
      if (!on)
         mosi = ~mosi;
      ticks(6);
   endtask

   // master clocks, drives on each rise, MSB first
   // callers build commands with zero low bits
   // Reply read late in the low half, as the port needs a few clocks
   task automatic xfer(input logic [15:0] tx, input int nbits,
         output logic [15:0] rx);
      rx = 16'h0000;
      for (int i = 15; i > 15 - nbits; i--) begin
         sclk = 1'b1;
         mosi = tx[i];
         ticks(4);
         sclk = 1'b0;
         ticks(4);
         rx[i] = miso_oe ? miso : 1'bx;
      end
   endtask
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the serial paged register port
`define CHK(got, exp) \
   begin \
      check_count++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk;
   logic rst_n;
   logic sclk;
   logic ss_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic result_valid;
   logic [2:0] result_index;
   logic [15:0] result_value;
   logic [15:0] ctl [10];
   logic [15:0] exp_ctl [10];
   logic [15:0] q[$];
   logic [15:0] rq[$];
   logic [15:0] w;
   int bad_count;
   int check_count;

   sprx_top dut (
      .clk(clk),
      .rst_n(rst_n),
      .sclk(sclk),
      .ss_n(ss_n),
      .mosi(mosi),
      .miso(miso),
      .miso_oe(miso_oe),
      .result_valid(result_valid),
      .result_index(result_index),
      .result_value(result_value),
      .touch_converter_control(ctl[0]),
      .touch_status(ctl[1]),
      .reference_control(ctl[2]),
      .soft_reset_control(ctl[3]),
      .touch_configuration(ctl[4]),
      .audio_control_one(ctl[5]),
      .dac_volume(ctl[6]),
      .audio_control_two(ctl[7]),
      .dac_power_control(ctl[8]),
      .audio_control_three(ctl[9])
   );

   sprx_host host (
      .clk(clk),
      .sclk(sclk),
      .ss_n(ss_n),
      .mosi(mosi),
      .miso(miso),
      .miso_oe(miso_oe)
   );

   // 50 MHz system clock
   always #10 clk = ~clk;

   // Command word: direction, page, start address, zero tail
   function automatic logic [15:0] cmd(logic rd, logic [3:0] pg,
         logic [5:0] a);
      return {rd, pg, a, 5'h00};
   endfunction

   // One framed access: command, then data words with their replies
   task automatic run(input logic [15:0] c, input logic [15:0] tx[$],
         output logic [15:0] rx[$]);
      logic [15:0] r;
      rx = {};
      host.select(1'b1);
      host.xfer(c, 16, r);
      foreach (tx[k]) begin
         host.xfer(tx[k], 16, r);
         rx.push_back(r);
      end
      host.select(1'b0);
   endtask

   // Read access compared word by word
   task automatic rd_chk(input logic [15:0] c, input logic [15:0] ex[$]);
      logic [15:0] z[$];
      logic [15:0] rx[$];
      foreach (ex[k]) z.push_back(16'h0000);
      run(c, z, rx);
      foreach (ex[k]) `CHK(rx[k], ex[k])
   endtask

   // Register outputs against the shadow, and miso released when idle
   task automatic ctl_chk();
      for (int k = 0; k < 10; k++) `CHK(ctl[k], exp_ctl[k])
      `CHK(miso_oe, 1'b0)
   endtask

   task automatic finish_test();
      if (bad_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Watchdog at 50k clocks, well above the expected run of some 20k
   initial begin
      #1000000;
      bad_count++;
      finish_test();
   end

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      result_valid = 1'b0;
      result_index = 3'h0;
      result_value = 16'h0000;
      bad_count = 0;
      check_count = 0;
      foreach (exp_ctl[k]) exp_ctl[k] = 16'h0000;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      ctl_chk();
      // Results clear on reset
      q = {};
      for (int i = 0; i < 8; i++) q.push_back(16'h0000);
      rd_chk(16'h8000, q);
      // Load results through the result port, address 4 is reserved
      q = {};
      for (int i = 0; i < 8; i++) begin
         result_valid = 1'b1;
         result_index = i[2:0];
         result_value = 16'h0a00 + 16'(i);
         @(negedge clk);
         q.push_back(i == 4 ? 16'h0000 : 16'h0a00 + 16'(i));
      end
      result_valid = 1'b0;
      // Host writes to results are dropped
      run(cmd(1'b0, 4'h0, 6'h00), {16'h5555, 16'h5555}, rq);
      rd_chk(cmd(1'b1, 4'h0, 6'h00), q);
      // Page 1 written from address 0, reserved address 02 skipped
      q = {};
      for (int i = 0; i < 6; i++) q.push_back(16'h1100 + 16'(i));
      run(16'h0800, q, rq);
      exp_ctl[0] = 16'h1100;
      exp_ctl[1] = 16'h1101;
      exp_ctl[2] = 16'h1103;
      exp_ctl[3] = 16'h1104;
      exp_ctl[4] = 16'h1105;
      ctl_chk();
      rd_chk(cmd(1'b1, 4'h1, 6'h00), {16'h1100, 16'h1101, 16'h0000,
         16'h1103, 16'h1104, 16'h1105});
      // Page 2 map including the first coefficients
      q = {};
      for (int i = 0; i < 9; i++) q.push_back(16'h2200 + 16'(i));
      run(cmd(1'b0, 4'h2, 6'h00), q, rq);
      exp_ctl[5] = 16'h2200;
      exp_ctl[6] = 16'h2202;
      exp_ctl[7] = 16'h2204;
      exp_ctl[8] = 16'h2205;
      exp_ctl[9] = 16'h2206;
      ctl_chk();
      rd_chk(cmd(1'b1, 4'h2, 6'h05), {16'h2205, 16'h2206, 16'h2207,
         16'h2208});
      // Page end: pointer parks, writes beyond vanish, reads give all ones
      run(cmd(1'b0, 4'h2, 6'h1d), {16'h2d1d, 16'h2d1e, 16'h2d1f,
         16'h2d20, 16'h2d21}, rq);
      ctl_chk();
      rd_chk(cmd(1'b1, 4'h2, 6'h1d), {16'h2d1d, 16'h0000, 16'h0000,
         16'hffff, 16'hffff});
      // Every reserved page code ignores writes and reads all ones
      for (int p = 3; p < 16; p++) begin
         run(cmd(1'b0, p[3:0], 6'h00), {16'hdead, 16'hbeef}, rq);
         rd_chk(cmd(1'b1, p[3:0], 6'h00), {16'hffff});
      end
      ctl_chk();
      // A cut-off half word is forgotten when select rises
      host.select(1'b1);
      host.xfer(cmd(1'b0, 4'h1, 6'h00), 8, w);
      host.select(1'b0);
      // Select held low: a second command is only data
      host.select(1'b1);
      host.xfer(cmd(1'b0, 4'h1, 6'h03), 16, w);
      host.xfer(16'h3333, 16, w);
      host.xfer(16'h0800, 16, w);
      host.xfer(16'h4444, 16, w);
      host.select(1'b0);
      exp_ctl[2] = 16'h3333;
      exp_ctl[3] = 16'h0800;
      exp_ctl[4] = 16'h4444;
      ctl_chk();
      // Mid-run reset with select held low: registers clear, and the
      // frame clocked after release is ignored as no select fall was seen
      host.select(1'b1);
      rst_n = 1'b0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      foreach (exp_ctl[k]) exp_ctl[k] = 16'h0000;
      repeat (3) @(negedge clk);
      host.xfer(cmd(1'b0, 4'h1, 6'h00), 16, w);
      host.xfer(16'h5a5a, 16, w);
      host.select(1'b0);
      ctl_chk();
      finish_test();
   end
endmodule
